/* File: design/sfc_pkg.sv */
// Shared constants and types for the servo fault code logic
package sfc_pkg;
    // Register byte offsets on the bus
    localparam logic [7:0] SFC_ERR_OFS   = 8'h00;
    localparam logic [7:0] SFC_CFG_OFS   = 8'h04;
    localparam logic [7:0] SFC_STAT_OFS  = 8'h08;
    localparam logic [7:0] SFC_MASK_OFS  = 8'h0c;
    localparam logic [7:0] SFC_PANEL_OFS = 8'h10;
    localparam logic [7:0] SFC_LIVE_OFS  = 8'h14;

    // Field positions of the error code word
    localparam int SFC_SUB_LSB  = 0;
    localparam int SFC_MAIN_LSB = 8;
    localparam int SFC_VLD_BIT  = 16;
    localparam int SFC_NCLR_BIT = 17;

    // Main error codes
    localparam logic [7:0] SFC_MAIN_LINK   = 8'h32;
    localparam logic [7:0] SFC_MAIN_STAT   = 8'h33;
    localparam logic [7:0] SFC_MAIN_PHASE  = 8'h37;
    localparam logic [7:0] SFC_MAIN_FORCED = 8'h57;
    localparam logic [7:0] SFC_MAIN_MOTOR  = 8'h5f;
    localparam logic [7:0] SFC_MAIN_SELF   = 8'h63;

    // Sub codes
    localparam logic [7:0] SFC_SUB_LOSS  = 8'h00;
    localparam logic [7:0] SFC_SUB_DATA  = 8'h01;
    localparam logic [7:0] SFC_SUB_PH_A  = 8'h00;
    localparam logic [7:0] SFC_SUB_PH_B  = 8'h01;
    localparam logic [7:0] SFC_SUB_PH_Z  = 8'h02;
    localparam logic [7:0] SFC_SUB_ZERO  = 8'h00;
    localparam logic [2:0] SFC_MOTOR_MAX = 3'h4;

    // Widths
    localparam int SFC_SCALE_BITS = 6;
    localparam int SFC_IRQ_W      = 2;

    // Interrupt status bits
    localparam int SFC_IRQ_RAISE = 0;
    localparam int SFC_IRQ_CLEAR = 1;

    // Reset values
    localparam logic [7:0]           SFC_LIMIT_RST = 8'h03;
    localparam logic [SFC_IRQ_W-1:0] SFC_MASK_RST  = 2'h0;

    // Timing: wire break must persist this long
    localparam int SFC_CLK_MHZ       = 40;
    localparam int SFC_WIRE_BREAK_US = 50;
    localparam int SFC_WIRE_BREAK_CYC = SFC_WIRE_BREAK_US * SFC_CLK_MHZ;

    // Latch state of the error record
    typedef enum logic [1:0] {
        SFC_ST_CLEAN,
        SFC_ST_SOFT,
        SFC_ST_HARD
    } sfc_state_t;
endpackage : sfc_pkg

/* File: design/sfc_sync2.sv */
// Two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/10ps
module sfc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    // First stage, read only by the second
    logic [W-1:0] meta_r;

    // Both stages reset to zero
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule : sfc_sync2

/* File: design/sfc_wire_mon.sv */
// Broken differential line detector for one quadrature phase
`timescale 1ns/10ps
module sfc_wire_mon #(
    parameter int BREAK_CYC = sfc_pkg::SFC_WIRE_BREAK_CYC
) (
    input  wire logic i_ref_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_pos,
    input  wire logic i_neg,
    output logic      o_broken
);
    import sfc_pkg::*;

    localparam int CW = $clog2(BREAK_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(BREAK_CYC - 1);

    // Cycles with both halves at one level
    logic [CW-1:0] same_cnt_r;
    // A healthy pair is always complementary
    logic          same;

    assign same = (i_pos == i_neg);

    // Count only an unbroken run; a glitch restarts it
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            same_cnt_r <= '0;
            o_broken   <= 1'b0;
        end else if (!same) begin
            same_cnt_r <= '0;
            o_broken   <= 1'b0;
        end else if (same_cnt_r == LAST) begin
            o_broken <= 1'b1;
        end else begin
            same_cnt_r <= same_cnt_r + 1'b1;
        end
    end

    a_wire_trip: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (same && same_cnt_r == LAST) |=> o_broken)
        else $error("phase line break not flagged");
endmodule : sfc_wire_mon

/* File: design/sfc_fault_top.sv */
// Fault detection, error code latch and bus registers of the servo drive
// Overview of operation
// - Repeated scale link loss raises 50.0
// - Corrupted scale data raises 50.1
// - Scale error bit n raises 51.n
// - 51 holds until power cycle; panel clear only pulses the scale
// - Broken A, B, Z line raises 55.0-2
// - Forced alarm input raises 87.0
// - Motor mismatch raises 95, sub 0-4
// - Self-diagnosis fault raises out-of-list code
// - Codes other than 87.0 ignore alarm clear input
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module sfc_fault_top
    import sfc_pkg::*;
#(
    parameter int BREAK_CYC = sfc_pkg::SFC_WIRE_BREAK_CYC
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic        i_hready,
    input  wire logic [31:0] i_hwdata,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Scale receiver, same clock
    input  wire logic        i_scale_frame_good,
    input  wire logic        i_scale_frame_miss,
    input  wire logic        i_scale_frame_bad,
    input  wire logic [sfc_pkg::SFC_SCALE_BITS-1:0] i_scale_error_code_bits,
    // Quadrature line pairs, asynchronous pins
    input  wire logic [2:0]  i_scale_phase_p,
    input  wire logic [2:0]  i_scale_phase_n,
    // Host pins, asynchronous
    input  wire logic        i_forced_alarm,
    input  wire logic        i_alarm_clear_input,
    // Motor recognition, same clock
    input  wire logic        i_motor_id_done,
    input  wire logic        i_motor_mismatch,
    input  wire logic [2:0]  i_motor_sub,
    // Self-diagnosis, same clock
    input  wire logic        i_self_diag_fault,
    input  wire logic [7:0]  i_self_diag_sub,
    // Error report
    output logic             o_err_active,
    output logic             o_err_nonclr,
    output logic      [7:0]  o_err_main,
    output logic      [7:0]  o_err_sub,
    output logic             o_scale_err_clr,
    output logic             o_irq
);
    import sfc_pkg::*;

    // Synchronised pin levels
    logic [2:0]  ph_p_s;
    logic [2:0]  ph_n_s;
    logic [1:0]  host_s;
    logic        fa_s;
    logic        aclr_s;
    logic        aclr_d_r;
    logic        aclr_rise;
    // Phase break flags
    logic [2:0]  ph_broken;
    // Link loss counter and limit
    logic [7:0]  miss_cnt_r;
    logic [7:0]  limit_r;
    // Detections
    logic        det_loss;
    logic        det_data;
    logic        det_stat;
    logic        det_phase;
    logic        det_motor;
    logic        det_self;
    logic        det_any;
    // Priority pick
    logic [7:0]  pick_main;
    logic [7:0]  pick_sub;
    logic        pick_hard;
    // Latch state
    sfc_state_t  st_r;
    logic        soft_clr;
    logic        raise;
    // Interrupt registers
    logic [SFC_IRQ_W-1:0] stat_r;
    logic [SFC_IRQ_W-1:0] mask_r;
    logic [SFC_IRQ_W-1:0] stat_nxt;
    logic [SFC_IRQ_W-1:0] w1c;
    // Bus data phase capture
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic        acc;
    logic [31:0] rd_nxt;
    // Pin synchronisers
    sfc_sync2 #(.W(3)) u_sync_p (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_scale_phase_p),
        .o_sync    (ph_p_s)
    );
    sfc_sync2 #(.W(3)) u_sync_n (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_scale_phase_n),
        .o_sync    (ph_n_s)
    );
    sfc_sync2 #(.W(2)) u_sync_host (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_forced_alarm, i_alarm_clear_input}),
        .o_sync    (host_s)
    );
    assign fa_s   = host_s[1];
    assign aclr_s = host_s[0];
    // One wire monitor per phase: A, B, Z
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_phase
            sfc_wire_mon #(.BREAK_CYC(BREAK_CYC)) u_mon (
                .i_ref_clk (i_ref_clk),
                .i_sys_rst (i_sys_rst),
                .i_pos     (ph_p_s[g]),
                .i_neg     (ph_n_s[g]),
                .o_broken  (ph_broken[g])
            );
        end
    endgenerate
    // Alarm clear edge; a held input clears only once
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            aclr_d_r <= 1'b0;
        end else begin
            aclr_d_r <= aclr_s;
        end
    end
    assign aclr_rise = aclr_s && !aclr_d_r;
    // Consecutive missed frames; a good frame restarts the run
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            miss_cnt_r <= 8'h00;
        end else if (i_scale_frame_good) begin
            miss_cnt_r <= 8'h00;
        end else if (i_scale_frame_miss && miss_cnt_r != 8'hff) begin
            miss_cnt_r <= miss_cnt_r + 8'h01;
        end
    end
    // Detections; a limit of zero acts as one
    assign det_loss  = miss_cnt_r != 8'h00 && miss_cnt_r >= limit_r;
    assign det_data  = i_scale_frame_bad;
    assign det_stat  = |i_scale_error_code_bits;
    assign det_phase = |ph_broken;
    assign det_motor = i_motor_id_done && i_motor_mismatch;
    assign det_self  = i_self_diag_fault;
    assign det_any   = det_loss || det_data || det_stat || det_phase
                    || det_motor || det_self || fa_s;
    // Fixed priority among simultaneous causes, internal first
    always_comb begin
        pick_main = SFC_MAIN_FORCED;
        pick_sub  = SFC_SUB_ZERO;
        pick_hard = 1'b1;
        if (det_self) begin
            pick_main = SFC_MAIN_SELF;
            pick_sub  = i_self_diag_sub;
        end else if (det_motor) begin
            pick_main = SFC_MAIN_MOTOR;
            // Out-of-range sub codes saturate at the top value
            pick_sub  = (i_motor_sub > SFC_MOTOR_MAX)
                      ? {5'h00, SFC_MOTOR_MAX} : {5'h00, i_motor_sub};
        end else if (det_phase) begin
            pick_main = SFC_MAIN_PHASE;
            pick_sub  = ph_broken[0] ? SFC_SUB_PH_A
                      : ph_broken[1] ? SFC_SUB_PH_B : SFC_SUB_PH_Z;
        end else if (det_stat) begin
            pick_main = SFC_MAIN_STAT;
            pick_sub  = SFC_SUB_ZERO;
            // Lowest set bit names the sub code
            for (int n = SFC_SCALE_BITS - 1; n >= 0; n--) begin
                if (i_scale_error_code_bits[n]) begin
                    pick_sub = 8'(n);
                end
            end
        end else if (det_loss) begin
            pick_main = SFC_MAIN_LINK;
            pick_sub  = SFC_SUB_LOSS;
        end else if (det_data) begin
            pick_main = SFC_MAIN_LINK;
            pick_sub  = SFC_SUB_DATA;
        end else begin
            pick_hard = 1'b0;
        end
    end
    // Clearable error goes once its cause is gone and clear rises
    assign soft_clr = st_r == SFC_ST_SOFT && aclr_rise && !fa_s;
    assign raise    = st_r == SFC_ST_CLEAN && det_any;
    // Error latch; only reset empties a hard error
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r       <= SFC_ST_CLEAN;
            o_err_main <= 8'h00;
            o_err_sub  <= 8'h00;
        end else begin
            unique case (st_r)
                SFC_ST_CLEAN: begin
                    if (det_any) begin
                        o_err_main <= pick_main;
                        o_err_sub  <= pick_sub;
                        st_r <= pick_hard ? SFC_ST_HARD : SFC_ST_SOFT;
                    end
                end
                SFC_ST_SOFT: begin
                    if (soft_clr) begin
                        st_r <= SFC_ST_CLEAN;
                    end
                end
                SFC_ST_HARD: st_r <= SFC_ST_HARD;
            endcase
        end
    end
    assign o_err_active = st_r != SFC_ST_CLEAN;
    assign o_err_nonclr = st_r == SFC_ST_HARD;
    // Bus: zero wait states, always OKAY
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign acc = i_hsel && i_htrans[1] && i_hready;
    // Read data built at address phase, shown in data phase
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (i_haddr[7:0])
            SFC_ERR_OFS: begin
                rd_nxt[SFC_MAIN_LSB +: 8] = o_err_main;
                rd_nxt[SFC_SUB_LSB +: 8]  = o_err_sub;
                rd_nxt[SFC_VLD_BIT]       = o_err_active;
                rd_nxt[SFC_NCLR_BIT]      = o_err_nonclr;
            end
            SFC_CFG_OFS:  rd_nxt[7:0] = limit_r;
            SFC_STAT_OFS: rd_nxt[SFC_IRQ_W-1:0] = stat_r;
            SFC_MASK_OFS: rd_nxt[SFC_IRQ_W-1:0] = mask_r;
            SFC_LIVE_OFS: begin
                rd_nxt[SFC_SCALE_BITS-1:0] = i_scale_error_code_bits;
                rd_nxt[8 +: 3] = ph_broken;
                rd_nxt[11]     = fa_s;
                rd_nxt[12]     = det_loss;
            end
            // Unmapped and write-only offsets read zero
            default: rd_nxt = 32'h0000_0000;
        endcase
    end
    // Address phase capture and read data register
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            o_hrdata  <= 32'h0000_0000;
        end else begin
            wr_pend_r <= acc && i_hwrite;
            if (acc) begin
                wr_addr_r <= i_haddr[7:0];
            end
            if (acc && !i_hwrite) begin
                o_hrdata <= rd_nxt;
            end
        end
    end
    // Loss limit and interrupt mask registers
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            limit_r <= SFC_LIMIT_RST;
            mask_r  <= SFC_MASK_RST;
        end else if (wr_pend_r) begin
            if (wr_addr_r == SFC_CFG_OFS) begin
                limit_r <= i_hwdata[7:0];
            end
            if (wr_addr_r == SFC_MASK_OFS) begin
                mask_r <= i_hwdata[SFC_IRQ_W-1:0];
            end
        end
    end
    // Panel command: one-cycle clear request to the scale
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_scale_err_clr <= 1'b0;
        end else begin
            o_scale_err_clr <= wr_pend_r && wr_addr_r == SFC_PANEL_OFS
                            && i_hwdata[0];
        end
    end
    // Sticky events, write one to clear; a new event wins
    always_comb begin
        w1c = '0;
        if (wr_pend_r && wr_addr_r == SFC_STAT_OFS) begin
            w1c = i_hwdata[SFC_IRQ_W-1:0];
        end
        stat_nxt = stat_r & ~w1c;
        stat_nxt[SFC_IRQ_RAISE] = stat_nxt[SFC_IRQ_RAISE] | raise;
        stat_nxt[SFC_IRQ_CLEAR] = stat_nxt[SFC_IRQ_CLEAR] | soft_clr;
    end
    // Status and level interrupt output
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            stat_r <= '0;
            o_irq  <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            o_irq  <= |(stat_nxt & mask_r);
        end
    end
    // Steps of a permitted clear
    sequence s_soft_held;
        st_r == SFC_ST_SOFT && o_err_main == SFC_MAIN_FORCED;
    endsequence
    sequence s_clr_edge;
        aclr_rise && !fa_s;
    endsequence

    a_loss_code: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (raise && det_loss && !det_self && !det_motor && !det_phase
         && !det_stat) |=> o_err_main == 8'h32 && o_err_sub == 8'h00)
        else $error("link loss code wrong");
    a_data_code: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (raise && det_data && !det_self && !det_motor && !det_phase
         && !det_stat && !det_loss)
        |=> o_err_main == 8'h32 && o_err_sub == 8'h01 && o_err_nonclr)
        else $error("data error code wrong");
    a_stat_code: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (raise && i_scale_error_code_bits[2:0] == 3'h4 && !det_self
         && !det_motor && !det_phase)
        |=> o_err_main == 8'h33 && o_err_sub == 8'h02)
        else $error("scale status code wrong");
    a_stat_held: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_err_active && o_err_main == SFC_MAIN_STAT)
        |=> o_err_active [*4])
        else $error("scale status error dropped");
    a_phase_code: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (raise && ph_broken == 3'h2 && !det_self && !det_motor)
        |=> o_err_main == 8'h37 && o_err_sub == 8'h01)
        else $error("phase break code wrong");
    a_forced_code: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (st_r == SFC_ST_CLEAN && fa_s && !det_loss && !det_data
         && !det_stat && !det_phase && !det_motor && !det_self)
        |=> o_err_main == 8'h57 && o_err_sub == 8'h00 && !o_err_nonclr)
        else $error("forced alarm code wrong");
    a_motor_code: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (raise && det_motor && !det_self)
        |=> o_err_main == 8'h5f && o_err_sub <= 8'h04)
        else $error("motor mismatch code wrong");
    a_self_code: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (raise && det_self) |=> o_err_main == 8'h63 && o_err_nonclr)
        else $error("self diagnosis code wrong");
    a_hard_clear: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_err_nonclr && aclr_rise) |=> o_err_active ##1 o_err_active)
        else $error("hard error cleared by input");
    a_soft_clear: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (s_soft_held ##0 s_clr_edge) |=> !o_err_active
        ##1 (stat_r[SFC_IRQ_CLEAR] || $past(w1c[SFC_IRQ_CLEAR])))
        else $error("clearable error not cleared");
    a_code_stable: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_err_active && !soft_clr)
        |=> $stable(o_err_main) && $stable(o_err_sub))
        else $error("latched code changed");
endmodule : sfc_fault_top

/* File: sim/sfc_scale_model.sv */
// Behavioural external position scale for the fault code bench
`timescale 1ns/10ps
module sfc_scale_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_sys_rst,
    input  wire logic [1:0] i_frame_req,
    input  wire logic [5:0] i_bits,
    input  wire logic [2:0] i_break,
    output logic            o_good,
    output logic            o_miss,
    output logic            o_bad,
    output logic      [5:0] o_bits,
    output logic      [2:0] o_p,
    output logic      [2:0] o_n
);
    logic tog_r;  // Quadrature activity
    // One registered frame result per request: 1 good, 2 miss, 3 bad
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            {o_good, o_miss, o_bad} <= 3'h0;
            o_bits <= 6'h00;
            tog_r <= 1'b0;
        end else begin
            o_good <= (i_frame_req == 2'h1);
            o_miss <= (i_frame_req == 2'h2);
            o_bad <= (i_frame_req == 2'h3);
            o_bits <= i_bits;
            tog_r <= ~tog_r;
        end
    end
    // A cut pair floats, so both halves sink to the bias level
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            o_p[k] = i_break[k] ? 1'b0 : tog_r;
            o_n[k] = i_break[k] ? 1'b0 : ~tog_r;
        end
    end
endmodule : sfc_scale_model

/* File: sim/testbench.sv */
// Self-checking bench for the servo fault code logic
`timescale 1ns/10ps
module testbench;
    import sfc_pkg::*;
    localparam int BRK = 8;       // Short wire break time
    localparam int LIMIT = 20000; // Cycle ceiling of the run
    logic        clk, rst;
    logic        hsel, hwrite, hrdy, hresp;
    logic [1:0]  htrans, freq;
    logic [2:0]  hsize, brk, php, phn, msub;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [5:0]  bits_req, bits;
    logic        good, miss, bad, falm, aclr, mdone, mmis, sdf;
    logic [7:0]  ssub, emain, esub;
    logic        eact, enclr, sclr, irq;
    int          fails, compares, cyc;

    sfc_scale_model sfc_scale_model_i (.i_ref_clk(clk), .i_sys_rst(rst),
        .i_frame_req(freq), .i_bits(bits_req), .i_break(brk),
        .o_good(good), .o_miss(miss), .o_bad(bad), .o_bits(bits),
        .o_p(php), .o_n(phn));
    sfc_fault_top #(.BREAK_CYC(BRK)) sfc_fault_top_i (.i_ref_clk(clk),
        .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hready(hrdy), .i_hwdata(hwdata), .o_hrdata(hrdata),
        .o_hreadyout(hrdy), .o_hresp(hresp), .i_scale_frame_good(good),
        .i_scale_frame_miss(miss), .i_scale_frame_bad(bad),
        .i_scale_error_code_bits(bits), .i_scale_phase_p(php),
        .i_scale_phase_n(phn), .i_forced_alarm(falm),
        .i_alarm_clear_input(aclr), .i_motor_id_done(mdone),
        .i_motor_mismatch(mmis), .i_motor_sub(msub),
        .i_self_diag_fault(sdf), .i_self_diag_sub(ssub),
        .o_err_active(eact), .o_err_nonclr(enclr), .o_err_main(emain),
        .o_err_sub(esub), .o_scale_err_clr(sclr), .o_irq(irq));

    // Free running clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Hang guard counts as a mismatch
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            fails++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Single word transfer; waits on ready, data taken at the last edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
        chk("hresp", hresp, 1'b0);
    endtask : bus
    // Power cycle with every cause removed first
    task automatic pwr();
        @(posedge clk);
        {falm, aclr, mdone, mmis, sdf} <= 5'h0;
        bits_req <= 6'h00;
        brk <= 3'h0;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask : pwr
    task automatic frame(input logic [1:0] k);
        @(posedge clk);
        freq <= k;
        @(posedge clk);
        freq <= 2'h0;
        repeat (2) @(posedge clk);
    endtask : frame
    // Bounded wait for the latch, then compare pins and register
    task automatic code(input logic [7:0] m, s, input logic nc);
        for (int n = 0; n < 200 && eact !== 1'b1; n++) @(posedge clk);
        chk("active", eact, 1'b1);
        chk("main", emain, m);
        chk("sub", esub, s);
        chk("nonclr", enclr, nc);
        bus(1'b0, SFC_ERR_OFS, 32'h0);
        chk("err reg", rd, {14'h0, nc, 1'b1, m, s});
    endtask : code
    task automatic clr_pin();
        @(posedge clk);
        aclr <= 1'b1;
        repeat (4) @(posedge clk);
        aclr <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : clr_pin

    // Reset values, read/write access, unmapped place
    task automatic t_regs();
        pwr();
        bus(1'b0, SFC_CFG_OFS, 32'h0);
        chk("cfg", rd, 32'h3);
        bus(1'b0, SFC_MASK_OFS, 32'h0);
        chk("mask", rd, 32'h0);
        bus(1'b1, 8'h18, 32'hffff_ffff);
        bus(1'b0, 8'h18, 32'h0);
        chk("unmapped", rd, 32'h0);
        bus(1'b1, SFC_CFG_OFS, 32'h5);
        bus(1'b0, SFC_CFG_OFS, 32'h0);
        chk("cfg rw", rd, 32'h5);
        chk("idle", eact, 1'b0);
    endtask : t_regs
    // Forced alarm, clear refused while high, interrupt path
    task automatic t_forced();
        pwr();
        bus(1'b1, SFC_MASK_OFS, 32'h1);
        falm <= 1'b1;
        code(SFC_MAIN_FORCED, SFC_SUB_ZERO, 1'b0);
        chk("irq up", irq, 1'b1);
        clr_pin();
        chk("still", eact, 1'b1);
        falm <= 1'b0;
        clr_pin();
        chk("cleared", eact, 1'b0);
        bus(1'b0, SFC_STAT_OFS, 32'h0);
        chk("stat", rd, 32'h3);
        bus(1'b1, SFC_MASK_OFS, 32'h0);
        repeat (2) @(posedge clk);
        chk("masked", irq, 1'b0);
        bus(1'b1, SFC_STAT_OFS, 32'h3);
        bus(1'b0, SFC_STAT_OFS, 32'h0);
        chk("w1c", rd, 32'h0);
    endtask : t_forced
    // Miss count restart, threshold, first error wins, clear refused
    task automatic t_loss();
        pwr();
        frame(2'h2);
        frame(2'h2);
        frame(2'h1);
        frame(2'h2);
        frame(2'h2);
        chk("below", eact, 1'b0);
        frame(2'h2);
        code(SFC_MAIN_LINK, SFC_SUB_LOSS, 1'b1);
        falm <= 1'b1;
        clr_pin();
        code(SFC_MAIN_LINK, SFC_SUB_LOSS, 1'b1);
        pwr();
        frame(2'h3);
        code(SFC_MAIN_LINK, SFC_SUB_DATA, 1'b1);
    endtask : t_loss
    // Scale bits n..5 set: lowest reported, panel pulse, no clear
    task automatic t_bits();
        for (int n = 0; n < 6; n++) begin
            pwr();
            bits_req <= 6'h3f << n;
            code(SFC_MAIN_STAT, 8'(n), 1'b1);
            bus(1'b0, SFC_LIVE_OFS, 32'h0);
            chk("live", rd, {26'h0, bits_req});
            bus(1'b1, SFC_PANEL_OFS, 32'h1);
            #1 chk("panel", sclr, 1'b1);
            @(posedge clk);
            #1 chk("panel end", sclr, 1'b0);
            bits_req <= 6'h00;
            clr_pin();
            chk("held", eact, 1'b1);
        end
    endtask : t_bits
    // Each cut line, motor codes with saturation, self fault priority
    task automatic t_misc();
        for (int k = 0; k < 3; k++) begin
            pwr();
            brk <= 3'h1 << k;
            code(SFC_MAIN_PHASE, 8'(k), 1'b1);
        end
        for (int s = 0; s < 6; s++) begin
            pwr();
            @(posedge clk);
            mdone <= 1'b1;
            mmis <= (s != 0);
            msub <= 3'(s);
            @(posedge clk);
            mdone <= 1'b0;
            repeat (3) @(posedge clk);
            chk("match ok", eact, s != 0);
            if (s != 0) code(SFC_MAIN_MOTOR, 8'(s > 4 ? 4 : s), 1'b1);
        end
        pwr();
        @(posedge clk);
        {mdone, mmis, sdf} <= 3'h7;
        ssub <= 8'h5a;
        @(posedge clk);
        {mdone, sdf} <= 2'h0;
        code(SFC_MAIN_SELF, 8'h5a, 1'b1);
        clr_pin();
        chk("self held", eact, 1'b1);
    endtask : t_misc

    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        {fails, compares, cyc} = '0;
        {rst, hsel, hwrite, falm, aclr, mdone, mmis, sdf} = 8'h80;
        {htrans, freq, brk, msub} = 10'h0;
        hsize = 3'h2;
        {haddr, hwdata} = 64'h0;
        {bits_req, ssub} = 14'h0;
        t_regs();
        t_forced();
        t_loss();
        t_bits();
        t_misc();
        end_of_test();
    end
endmodule : testbench
